// [hw/flash_self_program_pkg.sv]
// Function
// - update flash only in whole pages
// - software erases page before programming it
// - one word per store op, at addressed position
// - buffer loads before or after erase, kept
// - software saves unchanged words before erasing
// - array stays readable until erase, read-modify-write
// - erased page reads blank, old data gone
// - buffer words written in any order
// - same page address for erase and write
package flash_self_program_pkg;
	localparam int WORD_WIDTH = 16;
	localparam int PAGE_WORDS = 32;
	localparam int PAGE_COUNT = 128;
	localparam int WORD_BITS = $clog2(PAGE_WORDS);
	localparam int PAGE_BITS = $clog2(PAGE_COUNT);
	localparam int ADDR_BITS = PAGE_BITS + WORD_BITS;
	localparam logic [WORD_WIDTH-1:0] ERASED_WORD = 16'hFFFF;
	localparam logic [WORD_WIDTH-1:0] BUFFER_RESET = 16'hFFFF;

	typedef enum logic [1:0]
	{
		OP_LOAD  = 2'h0,
		OP_ERASE = 2'h1,
		OP_WRITE = 2'h2,
		OP_READ  = 2'h3
	} op_t;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'h0,
		ST_ERASE = 2'h1,
		ST_WRITE = 2'h2,
		ST_READ  = 2'h3
	} state_t;
endpackage

// [hw/flash_self_program_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface flash_self_program_if;
	logic                                            opValid;
	logic                                            opReady;
	flash_self_program_pkg::op_t                     opKind;
	logic [flash_self_program_pkg::ADDR_BITS-1:0]    opAddr;
	logic [flash_self_program_pkg::WORD_WIDTH-1:0]   opData;
	logic                                            readValid;
	logic [flash_self_program_pkg::WORD_WIDTH-1:0]   readData;

	modport device
	(
		input  opValid,
		output opReady,
		input  opKind,
		input  opAddr,
		input  opData,
		output readValid,
		output readData
	);

	modport core
	(
		output opValid,
		input  opReady,
		output opKind,
		output opAddr,
		output opData,
		input  readValid,
		input  readData
	);
endinterface
`default_nettype wire

// [hw/flash_self_program_page_buffer.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_page_buffer
#(
	// page geometry
	parameter int WW = flash_self_program_pkg::WORD_WIDTH,
	parameter int NW = flash_self_program_pkg::PAGE_WORDS,
	parameter int NP = flash_self_program_pkg::PAGE_COUNT
)
(
	// clock and reset
	input  wire logic                     mclk,
	input  wire logic                     reset_n,
	// processor side
	flash_self_program_if.device          bus,
	// status
	output logic                          busy
);
	localparam int WB = $clog2(NW);
	localparam int PB = $clog2(NP);
	localparam int AB = PB + WB;

	// geometry must fit the fixed interface layout
	if (WW != flash_self_program_pkg::WORD_WIDTH)
	begin
		$error("word width differs from the interface");
	end
	if (WB != flash_self_program_pkg::WORD_BITS)
	begin
		$error("word index width differs from the address split");
	end
	if (PB != flash_self_program_pkg::PAGE_BITS)
	begin
		$error("page index width differs from the address split");
	end
	if (NW < 2)
	begin
		$error("a page needs at least two words");
	end
	if ((1 << WB) != NW)
	begin
		$error("words per page must be a power of two");
	end
	if (NP < 2)
	begin
		$error("the array needs at least two pages");
	end
	if ((1 << PB) != NP)
	begin
		$error("page count must be a power of two");
	end

	// operation kind decode, shared by every take
	function automatic logic kindIs
	(
		input flash_self_program_pkg::op_t kind,
		input flash_self_program_pkg::op_t want
	);
		kindIs = (kind == want);
	endfunction

	// flat array index of one word in one page
	function automatic logic [AB-1:0] pageCell
	(
		input logic [PB-1:0] page,
		input logic [WB-1:0] word
	);
		pageCell = {page, word};
	endfunction

	// storage
	logic [WW-1:0]                  pageBuffer [NW];
	logic [WW-1:0]                  flashArray [NP*NW];
	// sequencer
	flash_self_program_pkg::state_t state;
	flash_self_program_pkg::state_t next_state;
	logic [PB-1:0]                  opPage;
	logic [PB-1:0]                  next_opPage;
	logic [WB-1:0]                  wordCount;
	logic [WB-1:0]                  next_wordCount;
	// read answer
	logic [WW-1:0]                  readData;
	logic                           readValid;
	logic                           next_readValid;

	// accepted operations
	wire          isIdle = (state == flash_self_program_pkg::ST_IDLE);
	wire          take = bus.opValid && isIdle;
	wire          takeLoad = take &&
		kindIs(bus.opKind, flash_self_program_pkg::OP_LOAD);
	wire          takeErase = take &&
		kindIs(bus.opKind, flash_self_program_pkg::OP_ERASE);
	wire          takeWrite = take &&
		kindIs(bus.opKind, flash_self_program_pkg::OP_WRITE);
	wire          takeRead = take &&
		kindIs(bus.opKind, flash_self_program_pkg::OP_READ);

	// address split
	wire [PB-1:0] addrPage = bus.opAddr[AB-1:WB];
	wire [WB-1:0] addrWord = bus.opAddr[WB-1:0];

	// page sweep
	wire          sweepErase = (state == flash_self_program_pkg::ST_ERASE);
	wire          sweepWrite = (state == flash_self_program_pkg::ST_WRITE);
	wire          lastWord = (wordCount == WB'(NW-1));
	wire [WB-1:0] nextCount = wordCount + WB'(1);
	wire [AB-1:0] sweepCell = pageCell(opPage, wordCount);
	wire [WW-1:0] erasedWord = WW'(flash_self_program_pkg::ERASED_WORD);
	wire [WW-1:0] programWord = flashArray[sweepCell] & pageBuffer[wordCount];

	// read path
	wire [AB-1:0] readCell = pageCell(addrPage, addrWord);
	wire [WW-1:0] cellWord = flashArray[readCell];

	// handshake and status
	assign bus.opReady = isIdle;
	assign bus.readData = readData;
	assign bus.readValid = readValid;
	assign busy = !isIdle;

	// next state of the sequencer
	always_comb
	begin
		next_state = state;
		next_opPage = opPage;
		next_wordCount = wordCount;
		next_readValid = 1'b0;
		case (state)
			// idle: take one operation
			flash_self_program_pkg::ST_IDLE:
			begin
				next_wordCount = '0;
				next_opPage = addrPage;
				if (takeErase)
					next_state = flash_self_program_pkg::ST_ERASE;
				else if (takeWrite)
					next_state = flash_self_program_pkg::ST_WRITE;
				else if (takeRead)
					next_state = flash_self_program_pkg::ST_READ;
			end
			// sweep one word per cycle
			flash_self_program_pkg::ST_ERASE,
			flash_self_program_pkg::ST_WRITE:
			begin
				next_wordCount = nextCount;
				if (lastWord)
					next_state = flash_self_program_pkg::ST_IDLE;
			end
			// one-cycle read answer
			flash_self_program_pkg::ST_READ:
			begin
				next_readValid = 1'b1;
				next_state = flash_self_program_pkg::ST_IDLE;
			end
			default:
				next_state = flash_self_program_pkg::ST_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			state <= flash_self_program_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			opPage <= '0;
		else
			opPage <= next_opPage;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			wordCount <= '0;
		else
			wordCount <= next_wordCount;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			readValid <= 1'b0;
		else
			readValid <= next_readValid;
	end

	// buffer loads, any order, kept across erase
	always_ff @(posedge mclk)
	begin
		if (takeLoad)
			pageBuffer[addrWord] <= bus.opData;
	end

	// array: whole-page erase and program, one word per cycle
	always_ff @(posedge mclk)
	begin
		if (sweepErase)
			flashArray[sweepCell] <= erasedWord;
		else if (sweepWrite)
			flashArray[sweepCell] <= programWord;
	end

	// reads see old data until erased
	always_ff @(posedge mclk)
	begin
		if (takeRead)
			readData <= cellWord;
	end
endmodule
`default_nettype wire

// [hw/flash_self_program_core_end.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_core_end
(
	// clock and reset
	input  wire logic                                          mclk,
	input  wire logic                                          reset_n,
	// user request
	input  wire logic                                          reqValid,
	output logic                                               reqReady,
	input  wire flash_self_program_pkg::op_t                   reqKind,
	input  wire logic [flash_self_program_pkg::ADDR_BITS-1:0]  reqAddr,
	input  wire logic [flash_self_program_pkg::WORD_WIDTH-1:0] reqData,
	// user read answer
	output logic                                               ansValid,
	output logic [flash_self_program_pkg::WORD_WIDTH-1:0]      ansData,
	// device side
	flash_self_program_if.core                                 bus
);
	// requests pass straight through; user keeps erase before write
	assign bus.opValid = reqValid;
	assign bus.opKind = reqKind;
	assign bus.opAddr = reqAddr;
	assign bus.opData = reqData;
	assign reqReady = bus.opReady;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ansValid <= 1'b0;
			ansData <= '0;
		end
		else
		begin
			ansValid <= bus.readValid;
			if (bus.readValid)
				ansData <= bus.readData;
		end
	end
endmodule
`default_nettype wire

// [testbench/flash_self_program_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_checker
(
	// clock and reset
	input wire logic                        mclk,
	input wire logic                        reset_n,
	// interface
	input wire logic                        opValid,
	input wire logic                        opReady,
	input wire flash_self_program_pkg::op_t opKind,
	input wire logic                        readValid,
	input wire logic                        busy
);
	wire take = opValid && opReady;
	wire tErase = take && opKind == flash_self_program_pkg::OP_ERASE;
	wire tWrite = take && opKind == flash_self_program_pkg::OP_WRITE;
	wire tRead = take && opKind == flash_self_program_pkg::OP_READ;
	wire tLoad = take && opKind == flash_self_program_pkg::OP_LOAD;
	wire tBusy = tErase || tWrite || tRead;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_erase_whole_page: assert property
		(tErase |=> !opReady[*8] ##24 !opReady ##1 opReady)
		else $error("erase length wrong");
	a_write_whole_page: assert property
		(tWrite |=> !opReady[*8] ##24 !opReady ##1 opReady)
		else $error("write length wrong");
	a_read_answers: assert property (tRead |-> ##2 readValid)
		else $error("read not answered");
	a_read_pulse: assert property (readValid |=> !readValid)
		else $error("read valid too long");
	a_read_after_busy: assert property (readValid |-> !$past(opReady))
		else $error("read valid without read");
	a_load_one_cycle: assert property (tLoad |=> opReady)
		else $error("load stalled");
	a_busy_from_take: assert property
		($rose(busy) |-> $past(tBusy))
		else $error("busy without an operation");
	c_load: cover property (tLoad);
	c_erase: cover property (tErase);
	c_write: cover property (tWrite);
	c_read: cover property (tRead);
endmodule
`default_nettype wire

// [testbench/tb_flash_self_program_page_buffer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_flash_self_program_page_buffer;
	logic mclk = 1'b0, reset_n = 1'b0, reqValid = 1'b0;
	logic busy, reqReady, ansValid;
	flash_self_program_pkg::op_t reqKind = flash_self_program_pkg::OP_LOAD;
	logic [11:0] reqAddr = 12'h000;
	logic [15:0] reqData = 16'h0000, ansData, got, mem [32];
	logic [6:0]  p;
	logic [4:0]  w;
	int seed = 32'h99AA26A7, num_errors = 0, cmp_count = 0, cyc = 0;
	flash_self_program_if bus ();
	flash_self_program_core_end flash_self_program_core_end_i (.mclk(mclk),
		.reset_n(reset_n), .reqValid(reqValid), .reqReady(reqReady),
		.reqKind(reqKind), .reqAddr(reqAddr), .reqData(reqData),
		.ansValid(ansValid), .ansData(ansData), .bus(bus));
	flash_self_program_page_buffer flash_self_program_page_buffer_i
		(.mclk(mclk), .reset_n(reset_n), .bus(bus), .busy(busy));
	flash_self_program_checker flash_self_program_checker_i (.mclk(mclk),
		.reset_n(reset_n), .opValid(bus.opValid), .opReady(bus.opReady),
		.opKind(bus.opKind), .readValid(bus.readValid), .busy(busy));
	always #12.5 mclk = ~mclk;
	task end_sim();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task op(input flash_self_program_pkg::op_t k, input logic [4:0] a,
		input logic [15:0] d);
		@(posedge mclk);
		reqValid <= 1'b1;
		reqKind <= k;
		reqAddr <= {p, a};
		reqData <= d;
		do @(negedge mclk); while (reqReady !== 1'b1);
		@(posedge mclk);
		reqValid <= 1'b0;
	endtask
	task rd(input logic [4:0] a);
		op(flash_self_program_pkg::OP_READ, a, 16'h0000);
		repeat (8) if (ansValid !== 1'b1) @(negedge mclk);
		got = ansData;
	endtask
	function logic [15:0] programmed(input logic [15:0] b);
		return flash_self_program_pkg::ERASED_WORD & b;
	endfunction
	task erase_chk();
		op(flash_self_program_pkg::OP_ERASE, 5'h00, 16'h0000);
		rd(5'h01);
		chk(got, flash_self_program_pkg::ERASED_WORD);
	endtask
	always @(posedge mclk)
		if (++cyc > 8000)
		begin
			num_errors++;
			end_sim();
		end
	initial
	begin
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		p = 7'($random(seed));
		for (int alt = 0; alt < 2; alt++)
		begin
			if (alt == 0)
				erase_chk();
			for (int i = 0; i < 32; i++)
			begin
				w = 5'(i * 13 + alt);
				if (alt == 1)
				begin
					rd(w);
					chk(got, mem[w]);
				end
				if (alt == 0 || 1'($random(seed)))
					mem[w] = 16'($random(seed));
				op(flash_self_program_pkg::OP_LOAD, w, mem[w]);
			end
			if (alt == 1)
				erase_chk();
			op(flash_self_program_pkg::OP_WRITE, 5'h1F, 16'h0000);
			for (int i = 0; i < 32; i++)
			begin
				rd(5'(i));
				chk(got, programmed(mem[i]));
			end
		end
		end_sim();
	end
endmodule
`default_nettype wire
